// ===== fswc_map.vh
`ifndef FSWC_MAP_VH
`define FSWC_MAP_VH
`define FSWC_ADDR_W        4
`define FSWC_OFS_CTRL      4'h0
`define FSWC_OFS_KEY       4'h1
`define FSWC_OFS_TABLE_POINTER    4'h2
`define FSWC_BIT_ERASE     4
`define FSWC_BIT_ERR       3
`define FSWC_BIT_WGATE     2
`define FSWC_BIT_START     1
`define FSWC_CTRL_MASK     8'h1e
`define FSWC_KEY_FIRST     8'h55
`define FSWC_KEY_SECOND    8'haa
`define FSWC_PTR_W         22
`define FSWC_BLK_LSB       10
`define FSWC_WRITE_NS      1000
`define FSWC_ERASE_NS      2000
`define FSWC_CLK_MHZ       250
`define FSWC_WRITE_CYC     ((`FSWC_WRITE_NS * `FSWC_CLK_MHZ + 999) / 1000)
`define FSWC_ERASE_CYC     ((`FSWC_ERASE_NS * `FSWC_CLK_MHZ + 999) / 1000)
`endif

// ===== fswc_unlock.v
`include "fswc_map.vh"
`default_nettype none
// Tracks the two-write key sequence; armed from the second key write until the next control or key write.
module fswc_unlock (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       key_wr,
  input  wire [7:0] key_data,
  input  wire       other_wr,
  input  wire       consume,
  output reg        armed_q
);
  reg first_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (consume) begin
      first_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (key_wr) begin
      first_q <= (key_data == `FSWC_KEY_FIRST);
      armed_q <= first_q && (key_data == `FSWC_KEY_SECOND);
    end else if (other_wr) begin
      first_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== fswc_timer.v
`include "fswc_map.vh"
`default_nettype none
// Down counter that times one programming cycle and pulses done at its end.
module fswc_timer #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         load,
  input  wire [W-1:0] count,
  output reg          busy_q,
  output reg          done_q
);
  reg [W-1:0] cnt_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= {W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load) begin
        cnt_q  <= count;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== fswc_top.v
`include "fswc_map.vh"
`default_nettype none
module fswc_top #(
  parameter TW        = 16,
  parameter WRITE_CYC = `FSWC_WRITE_CYC,
  parameter ERASE_CYC = `FSWC_ERASE_CYC
) (
  input  wire                      clk,
  input  wire                      rst_n,
  input  wire [`FSWC_ADDR_W-1:0]   addr,
  input  wire [7:0]                wdata,
  input  wire                      wr,
  input  wire                      rd,
  output reg  [7:0]                rdata,
  output reg                       flash_erase,
  output reg                       flash_write,
  output reg  [`FSWC_PTR_W-1:0]    flash_addr,
  output reg                       cpu_stall
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_WRITE = 3'b010;
  localparam ST_ERASE = 3'b100;

  reg  [2:0]              state_q;
  reg  [2:0]              state_d;
  reg                     erase_q;
  reg                     err_q;
  reg                     gate_q;
  reg                     start_q;
  reg                     boot_q;
  reg  [`FSWC_PTR_W-1:0]  ptr_q;
  wire                    armed;
  wire                    busy;
  wire                    done;

  wire ctrl_wr   = wr && (addr == `FSWC_OFS_CTRL);
  wire key_wr    = wr && (addr == `FSWC_OFS_KEY);
  wire ptr_wr    = wr && (addr == `FSWC_OFS_TABLE_POINTER);
  wire start_req = ctrl_wr && wdata[`FSWC_BIT_START] && !start_q;
  wire gate_new  = wdata[`FSWC_BIT_WGATE];
  wire legal     = start_req && armed && gate_new && gate_q;
  wire improper  = start_req && !legal;
  wire erase_sel = wdata[`FSWC_BIT_ERASE];

  fswc_unlock u_unlock (
    .clk      (clk),
    .rst_n    (rst_n),
    .key_wr   (key_wr),
    .key_data (wdata),
    .other_wr (wr && !key_wr),
    .consume  (ctrl_wr),
    .armed_q  (armed)
  );

  fswc_timer #(.W(TW)) u_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .load   (legal),
    .count  (erase_sel ? ERASE_CYC[TW-1:0] : WRITE_CYC[TW-1:0]),
    .busy_q (busy),
    .done_q (done)
  );

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (legal) state_d = erase_sel ? ST_ERASE : ST_WRITE;
      ST_WRITE: if (done) state_d = ST_IDLE;
      ST_ERASE: if (done) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      erase_q <= 1'b0;
      err_q   <= 1'b0;
      gate_q  <= 1'b0;
      start_q <= 1'b0;
      boot_q  <= 1'b0;
      ptr_q   <= {`FSWC_PTR_W{1'b0}};
    end else begin
      state_q <= state_d;
      boot_q  <= 1'b1;
      if (ptr_wr && !busy) begin
        ptr_q <= {{(`FSWC_PTR_W-8){1'b0}}, wdata};
      end
      if (ctrl_wr && !busy) begin
        gate_q  <= gate_new;
        erase_q <= erase_sel;
      end
      if (legal) begin
        start_q <= 1'b1;
      end else if (done) begin
        start_q <= 1'b0;
        if (state_q == ST_ERASE) begin
          erase_q <= 1'b0;
        end
      end
      // Error sets win over a software write of the same bit.
      if (improper) begin
        err_q <= 1'b1;
      end else if (!boot_q && start_q) begin
        err_q <= 1'b1;
      end else if (ctrl_wr) begin
        err_q <= wdata[`FSWC_BIT_ERR];
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata       <= 8'h00;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_addr  <= {`FSWC_PTR_W{1'b0}};
      cpu_stall   <= 1'b0;
    end else begin
      rdata <= 8'h00;
      if (rd && addr == `FSWC_OFS_CTRL) begin
        rdata <= {3'b000, erase_q, err_q, gate_q, start_q, 1'b0};
      end
      flash_erase <= (state_d == ST_ERASE);
      flash_write <= (state_d == ST_WRITE);
      cpu_stall   <= (state_d == ST_ERASE);
      if (legal) begin
        flash_addr <= erase_sel ?
          {ptr_q[`FSWC_PTR_W-1:`FSWC_BLK_LSB], {`FSWC_BLK_LSB{1'b0}}} : ptr_q;
      end
    end
  end
endmodule
`default_nettype wire

// ===== fswc_props.sv
`default_nettype none
module fswc_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        flash_erase,
  input wire logic        flash_write,
  input wire logic [21:0] flash_addr,
  input wire logic        cpu_stall
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_start; wr && addr == 4'h0 && wdata[1]; endsequence
  sequence s_idle; !flash_write && !flash_erase; endsequence
  property p_stall; cpu_stall == flash_erase; endproperty
  a_stall: assert property (p_stall) else $error("stall differs from erase");
  property p_blk; flash_erase |-> flash_addr[9:0] == 10'h000; endproperty
  a_blk: assert property (p_blk) else $error("erase address not block aligned");
  property p_rsv; rdata[7:5] == 3'h0 && !rdata[0]; endproperty
  a_rsv: assert property (p_rsv) else $error("unused bit reads one");
  property p_gate; s_start and s_idle and !wdata[2] |=> s_idle; endproperty
  a_gate: assert property (p_gate) else $error("cycle ran with gate off");
  property p_launch; $rose(flash_erase) |-> $past(wr) && $past(wdata[4]); endproperty
  a_launch: assert property (p_launch) else $error("erase without start");
  property p_wlen; $rose(flash_write) |-> flash_write [*4] ##[1:3] s_idle; endproperty
  a_wlen: assert property (p_wlen) else $error("write cycle length");
  property p_elen; $rose(flash_erase) |-> flash_erase [*8] ##[1:3] s_idle; endproperty
  a_elen: assert property (p_elen) else $error("erase cycle length");
  property p_busy; rd && addr == 4'h0 && flash_erase |=> rdata[1] && rdata[4]; endproperty
  a_busy: assert property (p_busy) else $error("start bit low while busy");
endmodule
bind fswc_top fswc_props u_props (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .flash_erase(flash_erase), .flash_write(flash_write),
  .flash_addr(flash_addr), .cpu_stall(cpu_stall));
`default_nettype wire

// ===== fswc_flash_model.sv
`default_nettype none
module fswc_flash_model (
  input wire logic        clk,
  input wire logic        flash_write,
  input wire logic        flash_erase
);
  timeunit 1ns;
  timeprecision 1ps;
  int   n_wr = 0;
  logic fw_q = 1'b0;
  // The array counts each write cycle it is handed.
  always @(posedge clk) begin
    fw_q <= flash_write;
    if (flash_write && !fw_q) n_wr <= n_wr + 1;
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        fe, fw, stall;
  logic [21:0] fa;
  int          error_cnt = 0;
  int          checks = 0;
  fswc_top #(.WRITE_CYC(4), .ERASE_CYC(8)) dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .flash_erase(fe), .flash_write(fw),
    .flash_addr(fa), .cpu_stall(stall));
  fswc_flash_model u_flash (.clk(clk), .flash_write(fw), .flash_erase(fe));
  task automatic check(input logic [21:0] got, input logic [21:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic go(input logic [7:0] c);
    wr_reg(4'h1, 8'h55);
    wr_reg(4'h1, 8'haa);
    wr_reg(4'h0, c);
    #1;
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 40 && (fw !== 1'b0 || fe !== 1'b0); i++) @(posedge clk) #1;
    if (i == 40) begin
      error_cnt++;
      stop_test();
    end
  endtask
  initial forever #2 clk = ~clk;
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(4'h0, 8'h00);
    wr_reg(4'h0, 8'he1);
    rd_chk(4'h0, 8'h00);
    wr_reg(4'h0, 8'h02);
    rd_chk(4'h0, 8'h08);
    wr_reg(4'h0, 8'h04);
    rd_chk(4'h0, 8'h04);
    $display("register test done");
    wr_reg(4'h2, 8'h5a);
    go(8'h06);
    check(fw, 1'b1);
    check(fa, 22'h5a);
    wait_idle();
    rd_chk(4'h0, 8'h04);
    $display("write test done");
    wr_reg(4'h2, 8'hff);
    go(8'h16);
    check(fe, 1'b1);
    check(fa, 22'h0);
    check(stall, 1'b1);
    wr_reg(4'h0, 8'h04);
    rd_chk(4'h0, 8'h16);
    wait_idle();
    rd_chk(4'h0, 8'h04);
    $display("erase test done");
    wr_reg(4'h1, 8'h55);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h1, 8'haa);
    wr_reg(4'h0, 8'h06);
    #1;
    check(fw, 1'b0);
    rd_chk(4'h0, 8'h0c);
    check(22'(u_flash.n_wr), 22'h1);
    $display("broken key test done");
    stop_test();
  end
endmodule
`default_nettype wire
